// File: include/ufa_pkg.sv
// Constants, types and register map of the receive frame check / address filter.
// Assumes a 32-bit Avalon-MM host using byte addresses; one register per word.
// ============================================================
// Package
package ufa_pkg;
  // Bus geometry
  localparam int          ADDR_W       = 6;
  localparam int          DATA_W       = 32;
  localparam int          BYTE_W       = 8;
  localparam int          DIV_W        = 16;
  // Register byte offsets
  localparam logic [5:0]  OFF_SCTL     = 6'h00;
  localparam logic [5:0]  OFF_PCTL     = 6'h04;
  localparam logic [5:0]  OFF_STATION_ADDRESS    = 6'h08;
  localparam logic [5:0]  OFF_SMASK    = 6'h0C;
  localparam logic [5:0]  OFF_RXDATA   = 6'h10;
  localparam logic [5:0]  OFF_BAUD     = 6'h14;
  localparam logic [5:0]  OFF_IRQ_STAT = 6'h18;
  localparam logic [5:0]  OFF_IRQ_EN   = 6'h1C;
  localparam logic [5:0]  OFF_IRQ_CLR  = 6'h20;
  // Serial control bit positions
  localparam int          SC_MODE0     = 7;
  localparam int          SC_MODE1     = 6;
  localparam int          SC_MPEN      = 5;
  localparam int          SC_REN       = 4;
  localparam int          SC_TB8       = 3;
  localparam int          SC_RB8       = 2;
  localparam int          SC_TI        = 1;
  localparam int          SC_RI        = 0;
  // Power control bit positions
  localparam int          PC_FESEL     = 6;
  // Interrupt status bit positions
  localparam int          IRQ_W        = 2;
  localparam int          IRQ_RX       = 0;
  localparam int          IRQ_FE       = 1;
  // Reset values
  localparam logic [7:0]  SCTL_RST     = 8'h00;
  localparam logic [7:0]  PCTL_RST     = 8'h00;
  localparam logic [7:0]  STATION_ADDRESS_RST    = 8'h00;
  localparam logic [7:0]  SMASK_RST    = 8'h00;
  localparam logic [15:0] BAUD_RST     = 16'h0010;
  // Frame geometry
  localparam logic [3:0]  BITS_8       = 4'h8;
  localparam logic [3:0]  BITS_9       = 4'h9;
  localparam logic [7:0]  ALL_ONES     = 8'hFF;

  typedef enum logic [1:0] {
    UFA_MODE_SHIFT,
    UFA_MODE_8BIT,
    UFA_MODE_9BIT_FIX,
    UFA_MODE_9BIT_VAR
  } ufa_mode_type;

  typedef struct packed {
    logic       ninth;
    logic       stop_ok;
    logic [7:0] data;
  } ufa_frame_type;
endpackage

// File: rtl/ufa_rx_filter.sv
// Serial receiver with framing error detect and hardware address filtering.
// Assumes rx_pin is asynchronous to sys_clk and an Avalon-MM master on sys_clk.
`timescale 1ns/1ps

module ufa_rx_filter #(
  parameter logic [15:0] BAUD_DEFAULT = ufa_pkg::BAUD_RST
) (
  // Clock and reset
  input  wire logic                       sys_clk,
  input  wire logic                       rst_b,
  // Avalon-MM slave
  input  wire logic [ufa_pkg::ADDR_W-1:0] avs_address,
  input  wire logic                       avs_read,
  input  wire logic                       avs_write,
  input  wire logic [ufa_pkg::DATA_W-1:0] avs_writedata,
  output logic      [ufa_pkg::DATA_W-1:0] avs_readdata,
  output logic                            avs_waitrequest,
  // Serial line
  input  wire logic                       rx_pin,
  // Status
  output logic                            receive_flag,
  output logic                            frame_error_flag,
  output logic                            irq
);
  import ufa_pkg::*;

  // ============================================================
  // Registers and nets
  typedef enum {RX_IDLE, RX_START, RX_DATA, RX_STOP} ufa_rx_state_type;

  ufa_rx_state_type state;
  ufa_frame_type    frame;
  ufa_mode_type     mode;
  logic             rx_meta;
  logic             rx_s;
  logic             serial_mode_bit0;
  logic             serial_mode_bit1;
  logic             multiproc_enable;
  logic             rx_enable;
  logic             tb8;
  logic             rb8;
  logic             ti;
  logic             frame_error_select;
  logic [7:0]       pctl_other;
  logic [7:0]       station_address;
  logic [7:0]       station_address_mask;
  logic [DIV_W-1:0] baud_div;
  logic [DIV_W-1:0] cnt;
  logic [3:0]       bit_cnt;
  logic [7:0]       shift;
  logic             ninth;
  logic             done;
  logic [IRQ_W-1:0] irq_stat;
  logic [IRQ_W-1:0] irq_en;
  logic             acc;
  logic             wr_hit;
  logic [7:0]       sctl_view;
  logic [7:0]       given_addr;
  logic [7:0]       bcast_addr;
  logic             given_hit;
  logic             bcast_hit;
  logic             addr_hit;
  logic             ri_set;
  logic             fe_set;
  logic [3:0]       nbits;

  // ============================================================
  // Bus handshake
  // One wait cycle per access keeps read data registered.
  assign acc    = (avs_read | avs_write) & ~avs_waitrequest;
  assign wr_hit = avs_write & ~avs_waitrequest;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      avs_waitrequest <= 1'b1;
    end else if (acc) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= ~(avs_read | avs_write);
    end
  end

  // ============================================================
  // Pin synchroniser
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_meta <= 1'b1;
      rx_s    <= 1'b1;
    end else begin
      rx_meta <= rx_pin;
      rx_s    <= rx_meta;
    end
  end

  // ============================================================
  // Receive framing
  assign mode  = ufa_mode_type'({serial_mode_bit0, serial_mode_bit1});
  assign nbits = (mode == UFA_MODE_9BIT_FIX || mode == UFA_MODE_9BIT_VAR) ? BITS_9 : BITS_8;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state   <= RX_IDLE;
      cnt     <= '0;
      bit_cnt <= '0;
      shift   <= '0;
      ninth   <= 1'b0;
      frame   <= '0;
      done    <= 1'b0;
    end else begin
      done <= 1'b0;
      unique case (state)
        RX_IDLE: begin
          bit_cnt <= '0;
          if (rx_enable && !rx_s) begin
            state <= RX_START;
            cnt   <= baud_div >> 1;
          end
        end
        RX_START: begin
          if (cnt != '0) begin
            cnt <= cnt - 1'b1;
          end else if (!rx_s) begin
            state <= RX_DATA;
            cnt   <= baud_div;
          end else begin
            state <= RX_IDLE;
          end
        end
        RX_DATA: begin
          if (cnt != '0) begin
            cnt <= cnt - 1'b1;
          end else begin
            cnt     <= baud_div;
            bit_cnt <= bit_cnt + 1'b1;
            if (bit_cnt == BITS_8) begin
              ninth <= rx_s;
            end else begin
              shift <= {rx_s, shift[7:1]};
            end
            if (bit_cnt + 1'b1 == nbits) begin
              // Shift mode has no stop bit to wait for
              if (mode == UFA_MODE_SHIFT) begin
                state <= RX_IDLE;
                done  <= 1'b1;
                frame <= '{ninth: 1'b0, stop_ok: 1'b1, data: {rx_s, shift[7:1]}};
              end else begin
                state <= RX_STOP;
              end
            end
          end
        end
        RX_STOP: begin
          if (cnt != '0) begin
            cnt <= cnt - 1'b1;
          end else begin
            state <= RX_IDLE;
            done  <= 1'b1;
            frame <= '{ninth: (nbits == BITS_9) ? ninth : 1'b0, stop_ok: rx_s, data: shift};
          end
        end
      endcase
    end
  end

  // ============================================================
  // Address comparison
  assign given_addr = station_address & station_address_mask;
  assign bcast_addr = station_address | station_address_mask;
  assign given_hit  = (frame.data & station_address_mask) == given_addr;
  assign bcast_hit  = (frame.data & bcast_addr) == bcast_addr;
  assign addr_hit   = given_hit | bcast_hit;

  always_comb begin
    ri_set = 1'b0;
    if (done) begin
      unique case (mode)
        UFA_MODE_SHIFT:    ri_set = 1'b1;
        UFA_MODE_8BIT:     ri_set = !multiproc_enable || (frame.stop_ok && addr_hit);
        UFA_MODE_9BIT_FIX,
        UFA_MODE_9BIT_VAR: ri_set = !multiproc_enable || (frame.ninth && addr_hit);
      endcase
    end
  end
  assign fe_set = done && mode != UFA_MODE_SHIFT && !frame.stop_ok;

  // ============================================================
  // Serial control register
  // Bit 7 view depends on the select bit; both halves keep their own storage.
  assign sctl_view = {frame_error_select ? frame_error_flag : serial_mode_bit0,
                      serial_mode_bit1, multiproc_enable, rx_enable,
                      tb8, rb8, ti, receive_flag};

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      serial_mode_bit0 <= SCTL_RST[SC_MODE0];
      serial_mode_bit1 <= SCTL_RST[SC_MODE1];
      multiproc_enable <= SCTL_RST[SC_MPEN];
      rx_enable        <= SCTL_RST[SC_REN];
      tb8              <= SCTL_RST[SC_TB8];
      ti               <= SCTL_RST[SC_TI];
    end else if (wr_hit && avs_address == OFF_SCTL) begin
      if (!frame_error_select) begin
        serial_mode_bit0 <= avs_writedata[SC_MODE0];
      end
      serial_mode_bit1 <= avs_writedata[SC_MODE1];
      multiproc_enable <= avs_writedata[SC_MPEN];
      rx_enable        <= avs_writedata[SC_REN];
      tb8              <= avs_writedata[SC_TB8];
      ti               <= avs_writedata[SC_TI];
    end
  end

  // Hardware sets win over a software write in the same cycle
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      receive_flag <= SCTL_RST[SC_RI];
      rb8          <= SCTL_RST[SC_RB8];
    end else if (ri_set) begin
      receive_flag <= 1'b1;
      rb8          <= (nbits == BITS_9) ? frame.ninth : frame.stop_ok;
    end else if (wr_hit && avs_address == OFF_SCTL) begin
      receive_flag <= avs_writedata[SC_RI];
      rb8          <= avs_writedata[SC_RB8];
    end
  end

  // Hardware only ever sets the error flag; clearing is left to software
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      frame_error_flag <= 1'b0;
    end else if (fe_set) begin
      frame_error_flag <= 1'b1;
    end else if (wr_hit && avs_address == OFF_SCTL && frame_error_select) begin
      frame_error_flag <= avs_writedata[SC_MODE0];
    end
  end

  // ============================================================
  // Configuration registers
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      frame_error_select   <= PCTL_RST[PC_FESEL];
      pctl_other           <= PCTL_RST;
      station_address      <= STATION_ADDRESS_RST;
      station_address_mask <= SMASK_RST;
      baud_div             <= BAUD_DEFAULT;
    end else if (wr_hit) begin
      unique case (avs_address)
        OFF_PCTL: begin
          frame_error_select <= avs_writedata[PC_FESEL];
          pctl_other         <= avs_writedata[BYTE_W-1:0];
        end
        OFF_STATION_ADDRESS: station_address      <= avs_writedata[BYTE_W-1:0];
        OFF_SMASK: station_address_mask <= avs_writedata[BYTE_W-1:0];
        OFF_BAUD:  baud_div             <= avs_writedata[DIV_W-1:0];
        default: ;
      endcase
    end
  end

  // ============================================================
  // Interrupts
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_stat <= '0;
      irq_en   <= '0;
      irq      <= 1'b0;
    end else begin
      irq_stat <= (irq_stat & ~((wr_hit && avs_address == OFF_IRQ_CLR) ?
                   avs_writedata[IRQ_W-1:0] : '0)) | {fe_set, ri_set};
      if (wr_hit && avs_address == OFF_IRQ_EN) begin
        irq_en <= avs_writedata[IRQ_W-1:0];
      end
      irq <= |(irq_stat & irq_en);
    end
  end

  // ============================================================
  // Read data
  // Unmapped and write-only words read as zero.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      avs_readdata <= '0;
    end else if (avs_read && avs_waitrequest) begin
      unique case (avs_address)
        OFF_SCTL:     avs_readdata <= DATA_W'(sctl_view);
        OFF_PCTL:     avs_readdata <= DATA_W'({pctl_other[7], frame_error_select,
                                               pctl_other[5:0]});
        OFF_STATION_ADDRESS:    avs_readdata <= DATA_W'(station_address);
        OFF_SMASK:    avs_readdata <= DATA_W'(station_address_mask);
        OFF_RXDATA:   avs_readdata <= DATA_W'({frame.ninth, frame.data});
        OFF_BAUD:     avs_readdata <= DATA_W'(baud_div);
        OFF_IRQ_STAT: avs_readdata <= DATA_W'(irq_stat);
        OFF_IRQ_EN:   avs_readdata <= DATA_W'(irq_en);
        default:      avs_readdata <= '0;
      endcase
    end
  end

  // ============================================================
  // Assertions
  property p_fe_set;
    @(posedge sys_clk) disable iff (!rst_b)
      done && mode != UFA_MODE_SHIFT && !frame.stop_ok |=> frame_error_flag;
  endproperty
  a_fe_set: assert property (p_fe_set) else $error("stop bit missing but no error");

  property p_mode_keep;
    @(posedge sys_clk) disable iff (!rst_b)
      wr_hit && avs_address == OFF_SCTL && frame_error_select |=> $stable(serial_mode_bit0);
  endproperty
  a_mode_keep: assert property (p_mode_keep) else $error("mode bit 0 written as error flag");

  property p_fe_hold;
    @(posedge sys_clk) disable iff (!rst_b)
      frame_error_flag && !(wr_hit && avs_address == OFF_SCTL) |=> frame_error_flag;
  endproperty
  a_fe_hold: assert property (p_fe_hold) else $error("error flag cleared by hardware");

  property p_no_filter;
    @(posedge sys_clk) disable iff (!rst_b)
      done && !multiproc_enable |=> receive_flag;
  endproperty
  a_no_filter: assert property (p_no_filter) else $error("unfiltered frame not flagged");

  property p_nine_miss;
    @(posedge sys_clk) disable iff (!rst_b)
      done && multiproc_enable && nbits == BITS_9 && !(frame.ninth && addr_hit)
      |=> !$rose(receive_flag);
  endproperty
  a_nine_miss: assert property (p_nine_miss) else $error("non-address frame flagged");

  property p_mode1_miss;
    @(posedge sys_clk) disable iff (!rst_b)
      done && multiproc_enable && mode == UFA_MODE_8BIT && !(frame.stop_ok && addr_hit)
      |=> !$rose(receive_flag);
  endproperty
  a_mode1_miss: assert property (p_mode1_miss) else $error("mode 1 flagged wrongly");

  property p_shift;
    @(posedge sys_clk) disable iff (!rst_b)
      done && mode == UFA_MODE_SHIFT |=> receive_flag && !$rose(frame_error_flag);
  endproperty
  a_shift: assert property (p_shift) else $error("shift mode frame filtered");

  property p_given;
    @(posedge sys_clk) disable iff (!rst_b)
      done && multiproc_enable && frame.ninth && nbits == BITS_9
      && ((frame.data ^ station_address) & station_address_mask) == '0 |=> receive_flag;
  endproperty
  a_given: assert property (p_given) else $error("given address not accepted");

  property p_bcast;
    @(posedge sys_clk) disable iff (!rst_b)
      done && multiproc_enable && frame.ninth && nbits == BITS_9
      && frame.data == ALL_ONES |=> receive_flag;
  endproperty
  a_bcast: assert property (p_bcast) else $error("broadcast not accepted");

  property p_reset_addr;
    @(posedge sys_clk) disable iff (!rst_b)
      $rose(rst_b) |-> station_address == STATION_ADDRESS_RST && station_address_mask == SMASK_RST;
  endproperty
  a_reset_addr: assert property (p_reset_addr) else $error("address not cleared");

  c_given: cover property (@(posedge sys_clk) disable iff (!rst_b)
    done && multiproc_enable && frame.ninth && given_hit);
  c_bcast: cover property (@(posedge sys_clk) disable iff (!rst_b)
    done && multiproc_enable && bcast_hit && !given_hit);
  c_fe: cover property (@(posedge sys_clk) disable iff (!rst_b) fe_set);
  c_shift: cover property (@(posedge sys_clk) disable iff (!rst_b)
    done && mode == UFA_MODE_SHIFT);

endmodule // ufa_rx_filter

// File: dv/ufa_line_master.sv
// Behavioural master node that sends address and data frames on the serial line.
// Assumes the bench sets bit_cycles to the receiver's baud divisor plus one.
`timescale 1ns/1ps

// ============================================================
// Serial line master
module ufa_line_master
  import ufa_pkg::*;
(
  // Clock
  input  wire logic        sys_clk,
  // Bit timing
  input  wire logic [15:0] bit_cycles,
  // Serial line
  output logic             rx_pin
);
  initial rx_pin = 1'b1;

  task automatic hold_bit(input logic level);
    rx_pin <= level;
    repeat (bit_cycles) @(posedge sys_clk);
  endtask

  // Stop low forges a framing fault; the line then idles high again
  task automatic send(input ufa_frame_type frame, input logic nine_bit);
    @(posedge sys_clk);
    hold_bit(1'b0);
    for (int i = 0; i < BYTE_W; i++) begin
      hold_bit(frame.data[i]);
    end
    if (nine_bit) begin
      hold_bit(frame.ninth);
    end
    hold_bit(frame.stop_ok);
    hold_bit(1'b1);
    hold_bit(1'b1);
  endtask
endmodule // ufa_line_master

// File: dv/ufa_rx_filter_tb.sv
// Self-checking bench for the receive frame check and address filter.
// Assumes the line master model and the assertions inside the design.
`timescale 1ns/1ps

module ufa_rx_filter_tb;
  import ufa_pkg::*;
  // ============================================================
  // Signals
  localparam logic [15:0] BAUD_DIV = 16'h0004;
  logic                   sys_clk;
  logic                   rst_b;
  logic [ADDR_W-1:0]      avs_address;
  logic                   avs_read;
  logic                   avs_write;
  logic [DATA_W-1:0]      avs_writedata;
  logic [DATA_W-1:0]      avs_readdata;
  logic                   avs_waitrequest;
  logic                   rx_pin;
  logic                   receive_flag;
  logic                   frame_error_flag;
  logic                   irq;
  logic [DATA_W-1:0]      rd;
  ufa_frame_type          fr;
  int                     n_errors;
  int                     tests_run;
  int                     cycles;

  ufa_rx_filter u_dut (
    .sys_clk(sys_clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .rx_pin(rx_pin), .receive_flag(receive_flag),
    .frame_error_flag(frame_error_flag), .irq(irq));

  ufa_line_master u_master (
    .sys_clk(sys_clk), .bit_cycles(BAUD_DIV + 16'h0001), .rx_pin(rx_pin));

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // Whole run is under two thousand cycles; the ceiling leaves ample margin
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      $display("[ERR] run_cycles expected below 20000 seen %0d", cycles);
      n_errors++;
      report_and_stop();
    end
  end

  // ============================================================
  // Tasks
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", what, exp, got);
      n_errors++;
    end
  endtask

  // Request held until waitrequest is sampled low; data taken at that edge
  task automatic bus(input logic wr_en, input logic [5:0] addr, input logic [31:0] data);
    @(posedge sys_clk);
    avs_address   <= addr;
    avs_writedata <= data;
    avs_read      <= ~wr_en;
    avs_write     <= wr_en;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [5:0] addr, input logic [31:0] data);
    bus(1'b1, addr, data);
  endtask

  task automatic rd_chk(input string what, input logic [5:0] addr, input logic [31:0] exp);
    bus(1'b0, addr, 32'h0);
    chk(what, exp, rd);
  endtask

  task automatic settle();
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask

  // Control byte picks mode, enable and receive; bit0 low also clears the flag
  task automatic frame_case(input logic [7:0] sctl, input logic [7:0] data,
                            input logic ninth, input logic stop_ok, input logic exp);
    ufa_frame_type f;
    f = '{ninth: ninth, stop_ok: stop_ok, data: data};
    wr(OFF_SCTL, {24'h0, sctl});
    u_master.send(f, sctl[SC_MODE0]);
    settle();
    chk("receive_flag", {31'h0, exp}, {31'h0, receive_flag});
    if (exp) begin
      bus(1'b0, OFF_RXDATA, 32'h0);
      chk("rx_data", {24'h0, data}, {24'h0, rd[7:0]});
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ============================================================
  // Tests
  initial begin
    rst_b         = 1'b0;
    avs_address   = '0;
    avs_read      = 1'b0;
    avs_write     = 1'b0;
    avs_writedata = '0;
    n_errors      = 0;
    tests_run     = 0;
    cycles        = 0;
    repeat (16) @(posedge sys_clk);
    rst_b <= 1'b1;
    rd_chk("sctl", OFF_SCTL, {24'h0, SCTL_RST});
    rd_chk("pctl", OFF_PCTL, {24'h0, PCTL_RST});
    rd_chk("station_address", OFF_STATION_ADDRESS, {24'h0, STATION_ADDRESS_RST});
    rd_chk("smask", OFF_SMASK, {24'h0, SMASK_RST});
    rd_chk("baud", OFF_BAUD, {16'h0, BAUD_RST});
    rd_chk("unmapped", 6'h24, 32'h0);
    wr(OFF_BAUD, {16'h0, BAUD_DIV});
    frame_case(8'h70, 8'h33, 1'b0, 1'b1, 1'b1);
    frame_case(8'h50, 8'h3C, 1'b0, 1'b1, 1'b1);
    frame_case(8'hD0, 8'h41, 1'b0, 1'b1, 1'b1);
    $display("test reset_and_open done");
    // Given address 1100 00X0, broadcast with bit1 ignored
    wr(OFF_STATION_ADDRESS, 32'h000000C0);
    wr(OFF_SMASK, 32'h000000FD);
    frame_case(8'hF0, 8'hC2, 1'b1, 1'b1, 1'b1);
    frame_case(8'hF0, 8'hC0, 1'b1, 1'b1, 1'b1);
    frame_case(8'hF0, 8'hC1, 1'b1, 1'b1, 1'b0);
    frame_case(8'hF0, 8'h41, 1'b1, 1'b1, 1'b0);
    frame_case(8'hF0, 8'hFF, 1'b1, 1'b1, 1'b1);
    frame_case(8'hF0, 8'hFD, 1'b1, 1'b1, 1'b1);
    frame_case(8'hF0, 8'hC0, 1'b0, 1'b1, 1'b0);
    frame_case(8'hB0, 8'hC2, 1'b1, 1'b1, 1'b1);
    frame_case(8'hB0, 8'hC1, 1'b1, 1'b1, 1'b0);
    frame_case(8'h70, 8'hC2, 1'b0, 1'b1, 1'b1);
    frame_case(8'h70, 8'hC1, 1'b0, 1'b1, 1'b0);
    frame_case(8'h70, 8'hC2, 1'b0, 1'b0, 1'b0);
    frame_case(8'h30, 8'hC1, 1'b0, 1'b1, 1'b1);
    $display("test address_filter done");
    // Error flag view of control bit 7
    wr(OFF_SCTL, 32'h00000050);
    wr(OFF_PCTL, 32'h00000040);
    wr(OFF_SCTL, 32'h00000050);
    settle();
    chk("frame_error_flag", 32'h0, {31'h0, frame_error_flag});
    fr = '{ninth: 1'b0, stop_ok: 1'b0, data: 8'h5A};
    u_master.send(fr, 1'b0);
    settle();
    chk("frame_error_flag", 32'h1, {31'h0, frame_error_flag});
    bus(1'b0, OFF_SCTL, 32'h0);
    chk("sctl_bit7", 32'h1, {31'h0, rd[SC_MODE0]});
    fr.stop_ok = 1'b1;
    u_master.send(fr, 1'b0);
    settle();
    chk("frame_error_flag", 32'h1, {31'h0, frame_error_flag});
    wr(OFF_SCTL, 32'h00000050);
    settle();
    chk("frame_error_flag", 32'h0, {31'h0, frame_error_flag});
    wr(OFF_PCTL, 32'h0);
    rd_chk("sctl", OFF_SCTL, 32'h00000050);
    $display("test frame_error done");
    // Interrupt: raise while masked, enable, clear
    wr(OFF_IRQ_CLR, 32'h00000003);
    settle();
    chk("irq", 32'h0, {31'h0, irq});
    fr.data = 8'h11;
    u_master.send(fr, 1'b0);
    settle();
    rd_chk("irq_stat", OFF_IRQ_STAT, 32'h00000001);
    chk("irq", 32'h0, {31'h0, irq});
    wr(OFF_IRQ_EN, 32'h00000001);
    settle();
    chk("irq", 32'h1, {31'h0, irq});
    wr(OFF_IRQ_STAT, 32'h0);
    rd_chk("irq_stat", OFF_IRQ_STAT, 32'h00000001);
    wr(OFF_IRQ_CLR, 32'h00000001);
    settle();
    chk("irq", 32'h0, {31'h0, irq});
    rd_chk("irq_stat", OFF_IRQ_STAT, 32'h0);
    $display("test interrupt done");
    report_and_stop();
  end
endmodule // ufa_rx_filter_tb
